/* File: hw/srl_bank.sv */
// Synthesizer FEC ratio, output gate and DPLL lock criterion registers.
// Assumes a byte-wide serial-port register access, one cycle writes.
// Functional notes
// - A 32-bit ratio register holds denominator in 15:0, numerator in 31:16.
// - Synth frequency equals base times multiplier times 16 times num over den.
// - Bit 0 of the output gate register enables the synth output, reset 0x01.
// - Bits 1:0 of the lock control register pick the lock criterion.
// - Codes 00..11 select 36us/10s, 1us/1s, 10us/1s and 10us/10s.
// - The lock control register resets to 0xaa, code 10.
// - The base frequency operand is a 16-bit unsigned value in hertz.
`timescale 1ns/1ps
`default_nettype none
`include "srl_consts.svh"
module srl_bank #(
	parameter int ERR_W = 32,
	parameter logic [31:0] WIN_SHORT = 32'(`SRL_WIN_1S_CYC),
	parameter logic [31:0] WIN_LONG = 32'(`SRL_WIN_10S_CYC)
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [15:0] base_frequency_value,
	input wire logic [15:0] base_multiplier_value,
	input wire logic [ERR_W-1:0] phase_err_ns,
	output logic [15:0] ratio_numerator_value,
	output logic [15:0] ratio_denominator_value,
	output logic [63:0] synth_freq_hz,
	output logic synth_out_en,
	output srl_pkg::srl_lock_sel_e lock_sel,
	output logic dpll_locked
);
	import srl_pkg::*;

	typedef struct packed {
		logic [31:0] fec_ratio_pair;
		logic [7:0] synthesizer_output_gate;
		logic [7:0] lock_criterion_ctrl;
		logic [7:0] rdata;
		logic [63:0] freq;
	} srl_bank_s;

	// Power-on values of every register
	localparam srl_bank_s RESET_ST = '{
		fec_ratio_pair: `SRL_RATIO_RESET,
		synthesizer_output_gate: `SRL_GATE_RESET,
		lock_criterion_ctrl: `SRL_LOCK_RESET,
		rdata: 8'h00,
		freq: 64'h0
	};

	srl_bank_s st;
	srl_bank_s next_st;
	logic [31:0] base_mult;
	logic [35:0] base_scaled;
	logic [63:0] product;
	logic [63:0] quotient;
	logic [15:0] den_safe;
	logic [1:0] byte_sel;
	logic hit_ratio;
	logic hit_gate;
	logic hit_lock;
	logic take_wr;
	logic take_rd;
	wire logic [3:0] ratio_wr;
	wire logic [31:0] ratio_new;
	wire logic [7:0] ratio_byte [4];
	logic [7:0] gate_new;
	logic [7:0] lock_new;
	logic [7:0] rd_byte;
	genvar gi;

	// ********************************************************
	// Address decode
	// ********************************************************
	always_comb begin
		hit_ratio = 1'b0;
		hit_gate = 1'b0;
		hit_lock = 1'b0;
		if (reg_addr >= `SRL_ADDR_RATIO_B0 &&
			reg_addr <= `SRL_ADDR_RATIO_B3) begin
			hit_ratio = 1'b1;
		end else if (reg_addr == `SRL_ADDR_GATE) begin
			hit_gate = 1'b1;
		end else if (reg_addr == `SRL_ADDR_LOCK) begin
			hit_lock = 1'b1;
		end
	end

	// Lane of the ratio word, meaningful only with hit_ratio
	assign byte_sel = 2'(reg_addr - `SRL_ADDR_RATIO_B0);
	assign take_wr = reg_wr && ce;
	assign take_rd = reg_rd && ce;

	// ********************************************************
	// Register writes
	// ********************************************************
	// No staging: a half-written ratio drives the outputs at once
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ratio_byte
			assign ratio_wr[gi] = take_wr && hit_ratio &&
				byte_sel == 2'(gi);
			assign ratio_new[gi*8 +: 8] =
				ratio_wr[gi] ? reg_wdata : ratio_byte[gi];
			assign ratio_byte[gi] = st.fec_ratio_pair[gi*8 +: 8];
		end
	endgenerate

	// Reserved bits are kept as written
	assign gate_new = (take_wr && hit_gate) ? reg_wdata :
		st.synthesizer_output_gate;
	assign lock_new = (take_wr && hit_lock) ? reg_wdata :
		st.lock_criterion_ctrl;

	// ********************************************************
	// Register reads
	// ********************************************************
	always_comb begin
		if (hit_ratio) begin
			rd_byte = ratio_byte[byte_sel];
		end else if (hit_gate) begin
			rd_byte = st.synthesizer_output_gate;
		end else if (hit_lock) begin
			rd_byte = st.lock_criterion_ctrl;
		end else begin
			// Unmapped addresses read as zero
			rd_byte = 8'h00;
		end
	end

	// ********************************************************
	// Next state
	// ********************************************************
	always_comb begin
		next_st = st;
		next_st.fec_ratio_pair = ratio_new;
		next_st.synthesizer_output_gate = gate_new;
		next_st.lock_criterion_ctrl = lock_new;
		// Read data holds until the next read; a read in a write
		// cycle still returns the old value
		if (take_rd) begin
			next_st.rdata = rd_byte;
		end
		next_st.freq = quotient;
	end

	// ********************************************************
	// Frequency arithmetic
	// ********************************************************
	// Base is 16-bit hertz, unsigned
	assign base_mult = 32'(base_frequency_value) *
		32'(base_multiplier_value);
	// Each stage sized so no intermediate can wrap
	assign base_scaled = 36'(base_mult) *
		36'(`SRL_SYNTH_SCALE);
	assign product = 64'(base_scaled) *
		64'(ratio_numerator_value);
	// Zero denominator would divide by zero; treat as one
	assign den_safe = (ratio_denominator_value == 16'h0000) ? 16'h0001 :
		ratio_denominator_value;
	assign quotient = product / {48'h0, den_safe};

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= RESET_ST;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// ********************************************************
	// Outputs
	// ********************************************************
	assign ratio_denominator_value = st.fec_ratio_pair[`SRL_DEN_LSB +: 16];
	assign ratio_numerator_value = st.fec_ratio_pair[`SRL_NUM_LSB +: 16];
	assign synth_out_en = st.synthesizer_output_gate[0];
	assign lock_sel = srl_lock_sel_e'(st.lock_criterion_ctrl[1:0]);
	assign reg_rdata = st.rdata;
	assign synth_freq_hz = st.freq;

	srl_lock_timer #(
		.ERR_W(ERR_W),
		.WIN_SHORT(WIN_SHORT),
		.WIN_LONG(WIN_LONG)
	) u_lock (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.sel(lock_sel),
		.phase_err_ns(phase_err_ns),
		.locked(dpll_locked)
	);
endmodule
`default_nettype wire

/* File: hw/srl_consts.svh */
// Constants for the synthesizer ratio and lock configuration bank.
// Assumes byte-wide register access at the printed addresses.
`ifndef SRL_CONSTS_SVH
`define SRL_CONSTS_SVH

// ********************************************************
// Register addresses
// ********************************************************
`define SRL_ADDR_RATIO_B0 8'h54
`define SRL_ADDR_RATIO_B3 8'h57
`define SRL_ADDR_GATE 8'h71
`define SRL_ADDR_LOCK 8'h72

// ********************************************************
// Fields and reset values
// ********************************************************
`define SRL_DEN_LSB 0
`define SRL_NUM_LSB 16
`define SRL_RATIO_RESET 32'h00010001
`define SRL_GATE_RESET 8'h01
`define SRL_LOCK_RESET 8'haa
`define SRL_SYNTH_SCALE 16

// ********************************************************
// Lock timing, in ns and seconds
// ********************************************************
`define SRL_CLK_NS 8
`define SRL_BOUND_36US_NS 36000
`define SRL_BOUND_1US_NS 1000
`define SRL_BOUND_10US_NS 10000
`define SRL_WIN_1S_S 1
`define SRL_WIN_10S_S 10
`define SRL_NS_PER_S 64'h3b9aca00
`define SRL_WIN_1S_CYC (`SRL_WIN_1S_S * `SRL_NS_PER_S / `SRL_CLK_NS)
`define SRL_WIN_10S_CYC (`SRL_WIN_10S_S * `SRL_NS_PER_S / `SRL_CLK_NS)

`endif

/* File: hw/srl_lock_timer.sv */
// Lock qualifier: bound on phase error held over a window.
// Assumes one phase error sample per enabled clock, in ns.
`timescale 1ns/1ps
`default_nettype none
`include "srl_consts.svh"
module srl_lock_timer #(
	parameter int ERR_W = 32,
	parameter logic [31:0] WIN_SHORT = 32'(`SRL_WIN_1S_CYC),
	parameter logic [31:0] WIN_LONG = 32'(`SRL_WIN_10S_CYC)
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire srl_pkg::srl_lock_sel_e sel,
	input wire logic [ERR_W-1:0] phase_err_ns,
	output logic locked
);
	import srl_pkg::*;

	typedef struct packed {
		logic [31:0] cnt;
		logic locked;
	} srl_tmr_s;

	srl_tmr_s st;
	srl_tmr_s next_st;
	logic [ERR_W-1:0] bound;
	logic [31:0] win;

	// ********************************************************
	// Criterion decode
	// ********************************************************
	always_comb begin
		case (sel)
		srl_lock_36us_10s: begin
			bound = ERR_W'(`SRL_BOUND_36US_NS);
			win = WIN_LONG;
		end
		srl_lock_1us_1s: begin
			bound = ERR_W'(`SRL_BOUND_1US_NS);
			win = WIN_SHORT;
		end
		srl_lock_10us_1s: begin
			bound = ERR_W'(`SRL_BOUND_10US_NS);
			win = WIN_SHORT;
		end
		default: begin
			bound = ERR_W'(`SRL_BOUND_10US_NS);
			win = WIN_LONG;
		end
		endcase
	end

	// ********************************************************
	// Window counter
	// ********************************************************
	always_comb begin
		next_st = st;
		if (phase_err_ns >= bound) begin
			// Any excursion restarts the window
			next_st.cnt = 32'h0;
			next_st.locked = 1'b0;
		end else if (st.cnt < win) begin
			next_st.cnt = st.cnt + 32'h1;
			next_st.locked = 1'b0;
		end else begin
			// Shrinking the window by selection locks at once
			next_st.locked = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign locked = st.locked;
endmodule
`default_nettype wire

/* File: hw/srl_pkg.sv */
// Types for the synthesizer ratio and lock configuration bank.
// Assumes srl_consts.svh for numeric values.
package srl_pkg;
	typedef enum logic [1:0] {
		srl_lock_36us_10s,
		srl_lock_1us_1s,
		srl_lock_10us_1s,
		srl_lock_10us_10s
	} srl_lock_sel_e;
endpackage

/* File: verif/srl_bank_chk.sv */
// Checker for the synth ratio, gate and lock bank.
// Assumes binding onto srl_bank; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module srl_bank_chk #(
	parameter int ERR_W = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [15:0] base_frequency_value,
	input wire logic [15:0] base_multiplier_value,
	input wire logic [ERR_W-1:0] phase_err_ns,
	input wire logic [15:0] ratio_numerator_value,
	input wire logic [15:0] ratio_denominator_value,
	input wire logic [63:0] synth_freq_hz,
	input wire logic synth_out_en,
	input wire srl_pkg::srl_lock_sel_e lock_sel,
	input wire logic dpll_locked
);
	import srl_pkg::*;
	// ***
	// Properties
	// ***
	logic [63:0] calc;
	logic [15:0] dv;
	logic bad;
	// Zero divisor read as one, so the model never divides by zero
	always_comb begin
		dv = ratio_denominator_value;
		if (dv == 16'h0) dv = 16'h1;
		calc = 64'(base_frequency_value) * 64'(base_multiplier_value)
			* 64'h10 * 64'(ratio_numerator_value) / 64'(dv);
		bad = phase_err_ns >= (lock_sel == 2'h0 ? 36000 :
			lock_sel == 2'h1 ? 1000 : 10000);
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_den_low_byte:
		assert property (ce && reg_wr && reg_addr == 8'h54 |=>
			ratio_denominator_value[7:0] == $past(reg_wdata)) else $error("den");
	a_num_high_byte:
		assert property (ce && reg_wr && reg_addr == 8'h57 |=>
			ratio_numerator_value[15:8] == $past(reg_wdata)) else $error("num");
	a_gate_bit:
		assert property (ce && reg_wr && reg_addr == 8'h71 |=>
			synth_out_en == $past(reg_wdata[0])) else $error("gate");
	a_sel_field:
		assert property (ce && reg_wr && reg_addr == 8'h72 |=>
			lock_sel == $past(reg_wdata[1:0])) else $error("sel");
	a_reset_state:
		assert property (disable iff (1'b0) rst |=> synth_out_en && !dpll_locked
			&& lock_sel == 2'h2 && ratio_numerator_value == 16'h1
			&& ratio_denominator_value == 16'h1) else $error("reset");
	a_freq_value:
		assert property ($past(ce) && !$past(rst) |->
			synth_freq_hz == $past(calc)) else $error("freq");
	a_lock_clears:
		assert property (ce && bad |=> !dpll_locked) else $error("lock");
	a_unmapped_zero:
		assert property (ce && reg_rd && !(reg_addr inside {[8'h54:8'h57],
			8'h71, 8'h72}) |=> reg_rdata == 8'h0) else $error("unmapped");
	a_ce_freeze:
		assert property (!ce |=> $stable(synth_out_en) && $stable(lock_sel)
			&& $stable(reg_rdata) && $stable(dpll_locked)
			&& $stable(synth_freq_hz)
			&& $stable({ratio_numerator_value, ratio_denominator_value}))
			else $error("freeze");
	c_freeze: cover property (!ce && reg_wr);
	c_lock: cover property ($rose(dpll_locked));
	c_ratio: cover property (ce && reg_wr && reg_addr == 8'h56);
	c_unmapped: cover property (ce && reg_rd && reg_addr == 8'h60);
endmodule
bind srl_bank srl_bank_chk #(.ERR_W(ERR_W)) i_chk (.*);
`default_nettype wire

/* File: verif/srl_bank_tb.sv */
// Self-checking bench for the synth ratio, gate and lock bank.
// Assumes lock windows shortened to 10 and 40 cycles.
`timescale 1ns/1ps
`default_nettype none
module srl_bank_tb;
	import srl_pkg::*;
	// ***
	// Stimulus and checks
	// ***
	localparam int WS = 10;
	localparam int WL = 40;
	logic clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0;
	logic synth_out_en, dpll_locked;
	logic [7:0] reg_addr = 8'h0, reg_wdata = 8'h0, reg_rdata;
	logic [15:0] base_frequency_value = 16'h9c40;
	logic [15:0] base_multiplier_value = 16'h0798;
	logic [15:0] ratio_numerator_value, ratio_denominator_value;
	logic [31:0] phase_err_ns = '1;
	logic [63:0] synth_freq_hz;
	srl_lock_sel_e lock_sel;
	int error_cnt = 0, n_checks = 0, n;
	int bnd [4] = '{36000, 1000, 10000, 10000};
	int win [4] = '{WL, WS, WS, WL};
	logic [7:0] ra [6] = '{8'h54, 8'h55, 8'h56, 8'h57, 8'h71, 8'h72};
	logic [7:0] rv [6] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'haa};
	always #4 clk = ~clk;
	srl_bank #(.WIN_SHORT(32'(WS)), .WIN_LONG(32'(WL))) i_dut (.*);
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(posedge clk) #1 reg_wr = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk) #1 {reg_rd, reg_addr} = {1'b1, a};
		@(posedge clk) #1 reg_rd = 0;
		chk(reg_rdata, e);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		#1 rst = 0;
		foreach (ra[i]) rd(ra[i], rv[i]);
		chk(synth_freq_hz, 64'(base_frequency_value) * 64'h798 * 64'h10);
		$display("test reset done");
		wr(8'h54, 8'hed);
		wr(8'h55, 8'h00);
		wr(8'h56, 8'hff);
		wr(8'h57, 8'h00);
		@(posedge clk) #1;
		chk({ratio_numerator_value, ratio_denominator_value}, 32'hff00ed);
		chk(synth_freq_hz, 64'h9c40 * 64'h798 * 64'h10 * 64'hff / 64'hed);
		rd(8'h56, 8'hff);
		wr(8'h54, 8'h01);
		wr(8'h56, 8'h01);
		@(posedge clk) #1;
		chk(synth_freq_hz, 64'h9c40 * 64'h798 * 64'h10);
		$display("test ratio done");
		wr(8'h71, 8'h00);
		chk(synth_out_en, 0);
		wr(8'h71, 8'h01);
		chk(synth_out_en, 1);
		wr(8'h60, 8'h5a);
		rd(8'h60, 8'h00);
		// Enable low: write ignored, read data held
		ce = 0;
		wr(8'h71, 8'h00);
		rd(8'h72, 8'h00);
		chk(synth_out_en, 1);
		ce = 1;
		rd(8'h71, 8'h01);
		$display("test gate done");
		// Big error first so every code starts its window from zero
		for (int c = 0; c < 4; c++) begin
			phase_err_ns = '1;
			wr(8'h72, 8'(c));
			chk(lock_sel, 64'(c));
			phase_err_ns = 32'(bnd[c] - 1);
			n = 0;
			while (dpll_locked !== 1'b1 && n < 100) begin
				@(posedge clk) #1 n++;
			end
			chk(n >= win[c] && n <= win[c] + 2, 1);
			if (n >= 100) finish_test();
			phase_err_ns = 32'(bnd[c]);
			@(posedge clk) #1;
			chk(dpll_locked, 0);
		end
		$display("test lock done");
		finish_test();
	end
endmodule
`default_nettype wire
